/* ram_pwr_pkg.sv */
/*
  shared types and constants for the embedded ram block with power-up
  output clearing (not in the flow-through build) and clock/read gating (no read gating in the flow-through build).
  assumes a single synchronous clock; reset_in stands in for power-up.
*/
package ram_pwr_pkg;

  // ****************************************
  // memory kinds
  // ****************************************
  typedef enum logic [1:0] {
    KIND_MEDIUM,
    KIND_LARGE,
    KIND_ARRAY
  } mem_kind_t;

  localparam int ADDR_W_DEF = 8;
  localparam int DATA_W_DEF = 16;
  localparam logic ZERO_BIT  = 1'h0;
  // fill bit of the stand-in initial image; ones so it differs from clear
  localparam logic PRELOAD_BIT    = 1'h1;
  localparam int   GATE_RUN_W     = 4;
  localparam int   COVER_GATE_RUN = 3;

  // ****************************************
  // request carrier
  // ****************************************
  typedef struct packed {
    logic       clk_en;
    logic       rd_en;
    logic       wr_en;
  } mem_ctl_t;

endpackage : ram_pwr_pkg

/* ram_pwr_block.sv */
/*
  single-port embedded ram with power-up cleared output (except in the flow-through build), clock-enable
  gating and read-enable gating (the flow-through build shows the addressed word whatever the read enable).
  assumes user logic drives all inputs synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module ram_pwr_block #(
  parameter ram_pwr_pkg::mem_kind_t KIND = ram_pwr_pkg::KIND_MEDIUM,
  parameter bit OUT_REG   = 1'b1,
  parameter int ADDR_W    = ram_pwr_pkg::ADDR_W_DEF,
  parameter int DATA_W    = ram_pwr_pkg::DATA_W_DEF,
  parameter bit PRELOAD   = 1'b0
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  input  wire ram_pwr_pkg::mem_ctl_t ctl_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     data_in,
  output logic      [DATA_W-1:0]     q_out
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [DATA_W-1:0] CLEAR = {DATA_W{ram_pwr_pkg::ZERO_BIT}};

  // ****************************************
  // decode helpers
  // ****************************************
  // an access only counts on an edge that the clock enable lets through
  function automatic logic fires(
    input ram_pwr_pkg::mem_ctl_t ctl,
    input logic                  strobe
  );
    return ctl.clk_en & strobe;
  endfunction : fires

  // ****************************************
  // storage
  // ****************************************
  // no reset on the array: contents stay unknown unless preloaded
  // the fill stands in for an initial image; without it every word is
  // unknown, so user logic must write a word before it reads it
  localparam logic [DATA_W-1:0] FILL = PRELOAD ?
    {DATA_W{ram_pwr_pkg::PRELOAD_BIT}} : {DATA_W{1'bx}};
  logic [DATA_W-1:0] mem [DEPTH] = '{default: FILL};

  wire do_write = fires(ctl_in, ctl_in.wr_en);
  wire do_read  = fires(ctl_in, ctl_in.rd_en);
  wire [DATA_W-1:0] rd_word = mem[addr_in];
  // array kind without output stage flows the current word straight out
  wire comb_path = (KIND == ram_pwr_pkg::KIND_ARRAY) && !OUT_REG;

  always_ff @(posedge clk_sys_in) begin
    if (do_write) begin
      mem[addr_in] <= data_in;
    end
  end

  // ****************************************
  // read stages
  // ****************************************
  // read latch: cleared at power-up even when preloaded
  logic [DATA_W-1:0] rd_latch;
  logic [DATA_W-1:0] rd_reg;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_latch <= CLEAR;
    end else if (do_read) begin
      rd_latch <= rd_word;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_reg <= CLEAR;
    end else if (ctl_in.clk_en) begin
      rd_reg <= rd_latch;
    end
  end

  // output muxing trades a true flop output for the flow-through mode
  always_comb begin
    if (comb_path) begin
      q_out = rd_word;
    end else if (OUT_REG) begin
      q_out = rd_reg;
    end else begin
      q_out = rd_latch;
    end
  end

  // ****************************************
  // check helpers
  // ****************************************
  // long freezes are checked through a small run counter and snapshots
  // of both read stages, not a long repetition that tools would unroll
  logic [ram_pwr_pkg::GATE_RUN_W-1:0] gate_run;
  logic [DATA_W-1:0]                  latch_snap;
  logic [DATA_W-1:0]                  reg_snap;

  wire gate_first = !ctl_in.clk_en && (gate_run == '0);
  wire gate_full  = (gate_run == '1);

  // the counter saturates so a very long idle spell cannot wrap it
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      gate_run <= '0;
    end else if (ctl_in.clk_en) begin
      gate_run <= '0;
    end else if (!gate_full) begin
      gate_run <= gate_run + 1'b1;
    end
  end

  // snapshots only matter while the run counter is non-zero
  always_ff @(posedge clk_sys_in) begin
    if (gate_first) begin
      latch_snap <= rd_latch;
      reg_snap   <= rd_reg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_reset_clears: assert property (@(posedge clk_sys_in)
    reset_in && !comb_path |=> q_out == CLEAR)
    else $error("output not cleared after reset");
  a_hold_no_ce: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) !ctl_in.clk_en |=> $stable(rd_reg)
      && $stable(rd_latch))
    else $error("registers moved without clock enable");
  a_read_loads: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) do_read |=> rd_latch == $past(rd_word))
    else $error("read did not load addressed word");
  a_no_read_hold: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) ctl_in.clk_en && !ctl_in.rd_en
      |=> $stable(rd_latch))
    else $error("read output changed without read enable");
  a_write_store: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) do_write |=> mem[$past(addr_in)]
      == $past(data_in))
    else $error("write data not stored");
  a_reg_follows: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) ctl_in.clk_en && OUT_REG && !comb_path
      |=> q_out == $past(rd_latch))
    else $error("output stage did not follow read latch");
  a_comb_flow: assert property (@(posedge clk_sys_in)
    comb_path |-> q_out == rd_word)
    else $error("flow-through output wrong");
  a_preload_clear: assert property (@(posedge clk_sys_in)
    reset_in |=> rd_latch == CLEAR)
    else $error("read latch not cleared");

  // gated runs, flow-through writes, output-stage reset, read-latch hold and the latch-only build
  a_gate_freeze: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    gate_run != '0
      |-> rd_latch == latch_snap)
    else $error("read latch moved during a gated run");

  a_gate_reg_freeze: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    gate_run != '0
      |-> rd_reg == reg_snap)
    else $error("output stage moved during a gated run");

  a_gate_q_hold: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !ctl_in.clk_en && !comb_path
      |=> $stable(q_out))
    else $error("output moved on a gated edge");

  a_flow_write: assert property (@(posedge clk_sys_in)
    comb_path && do_write ##1
    addr_in == $past(addr_in)
      |-> q_out == $past(data_in))
    else $error("flow-through output missed the written word");

  a_reg_cleared: assert property (@(posedge clk_sys_in)
    reset_in
      |=>
    rd_reg == CLEAR)
    else $error("output stage not cleared");

  a_read_only_en: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !do_read
      |=> $stable(rd_latch))
    else $error("read latch loaded without a read");

  a_latch_out_hold: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !OUT_REG && !comb_path && !do_read
      |=> $stable(q_out))
    else $error("latch output changed without a read");

  a_lat_mode_load: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !OUT_REG && !comb_path && do_read
      |=> q_out == $past(rd_word))
    else $error("latch output missed the read word");

  c_write: cover property (@(posedge clk_sys_in) do_write);
  c_read: cover property (@(posedge clk_sys_in) do_write ##1 do_read);
  c_gated: cover property (@(posedge clk_sys_in)
    !ctl_in.clk_en ##1 do_read);
  c_freeze_run: cover property (@(posedge clk_sys_in)
    gate_run == ram_pwr_pkg::COVER_GATE_RUN);
  c_restart_read: cover property (@(posedge clk_sys_in)
    reset_in ##1 !reset_in ##[1:40] do_read);

endmodule : ram_pwr_block

/* ram_user_model.sv */
/* user-logic request driver facing ram_pwr_block.
   assumes callers step it once per clock; it drives 1 ns after the edge. */
`timescale 1ns/1ps
module ram_user_model (
  input  wire logic            clk_in,
  output ram_pwr_pkg::mem_ctl_t ctl_out,
  output logic [7:0]           addr_out,
  output logic [15:0]          data_out
);
  initial begin
    ctl_out = '0;
    addr_out = '0;
    data_out = '0;
  end
  // one request per edge; held until the next call
  task automatic op(input logic [2:0] c, input logic [7:0] a,
                    input logic [15:0] d);
    @(posedge clk_in);
    #1;
    ctl_out = c;
    addr_out = a;
    data_out = d;
  endtask : op
endmodule : ram_user_model

/* ram_pwr_block_tb.sv */
/* bench for ram_pwr_block: power-up output, write/read and gating.
   assumes four builds share one request stream; reads hit written words. */
`timescale 1ns/1ps
module ram_pwr_block_tb;
  logic                  clk_sys_in = 1'b0;
  logic                  reset_in   = 1'b1;
  ram_pwr_pkg::mem_ctl_t ctl;
  logic [7:0]            addr;
  logic [15:0]           data, q, d, held, shadow [256];
  logic [15:0]           q_pre, q_flow, q_lat;
  int                    err_count = 0, num_checks = 0;
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  ram_user_model i_ram_user_model (.clk_in(clk_sys_in), .ctl_out(ctl),
    .addr_out(addr), .data_out(data));
  ram_pwr_block i_ram_pwr_block (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .ctl_in(ctl), .addr_in(addr), .data_in(data),
    .q_out(q));
  ram_pwr_block #(.KIND(ram_pwr_pkg::KIND_ARRAY), .PRELOAD(1'b1))
    i_ram_pwr_block_pre (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .ctl_in(ctl), .addr_in(addr), .data_in(data), .q_out(q_pre));
  ram_pwr_block #(.KIND(ram_pwr_pkg::KIND_ARRAY), .OUT_REG(1'b0),
    .PRELOAD(1'b1)) i_ram_pwr_block_flow (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .ctl_in(ctl), .addr_in(addr), .data_in(data),
    .q_out(q_flow));
  ram_pwr_block #(.KIND(ram_pwr_pkg::KIND_LARGE), .OUT_REG(1'b0))
    i_ram_pwr_block_lat (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .ctl_in(ctl), .addr_in(addr), .data_in(data), .q_out(q_lat));
  function automatic logic [15:0] rd_exp(input logic [7:0] a);
    return shadow[a];
  endfunction : rd_exp
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t q %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    logic [7:0] a;
    void'($urandom(14));
    repeat (20) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    chk(q, 16'h0000);
    chk(q_pre, 16'h0000);
    chk(q_lat, 16'h0000);
    chk(q_flow, {16{ram_pwr_pkg::PRELOAD_BIT}});
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hFF : 8'($urandom);
      d = (i == 1) ? 16'hFFFF : 16'($urandom);
      shadow[a] = d;
      i_ram_user_model.op(3'b101, a, d);
      i_ram_user_model.op(3'b110, a, ~d);
      chk(q_flow, d);
      repeat (2) i_ram_user_model.op(3'b100, ~a, ~d);
      chk(q, rd_exp(a));
      chk(q_pre, rd_exp(a));
      chk(q_lat, rd_exp(a));
    end
    $display("test write-read done");
    held = q;
    // frozen edges carry a write and a read that must both be lost
    repeat (3) i_ram_user_model.op(3'b011, a, ~held);
    repeat (2) i_ram_user_model.op(3'b100, ~a, ~held);
    chk(q, held);
    i_ram_user_model.op(3'b110, a, 16'h0000);
    repeat (2) i_ram_user_model.op(3'b100, a, 16'h0000);
    chk(q, held);
    $display("test gating done");
    reset_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    chk(q, 16'h0000);
    chk(q_pre, 16'h0000);
    chk(q_lat, 16'h0000);
    chk(q_flow, rd_exp(a));
    i_ram_user_model.op(3'b110, a, 16'h0000);
    repeat (2) i_ram_user_model.op(3'b100, a, 16'h0000);
    chk(q, rd_exp(a));
    chk(q_lat, rd_exp(a));
    $display("test reset done");
    conclude();
  end
  initial begin
    #(5 * 2000);
    err_count++;
    conclude();
  end
endmodule : ram_pwr_block_tb
